/* cmd_consts.vh */
// Constants for the remote command parser with boost guard
`ifndef CMD_CONSTS_VH
`define CMD_CONSTS_VH
`define CH_SPACE      8'h20
`define CH_SEMI       8'h3B
`define CH_LF         8'h0A
`define CH_CR         8'h0D
`define CH_QUERY      8'h3F
`define CH_PLUS       8'h2B
`define CH_MINUS      8'h2D
`define CH_DOT        8'h2E
`define CH_E          8'h45
`define CH_ZERO       8'h30
`define CH_NINE       8'h39
`define BW_WIDTH      3
`define BW_1MHZ       3'h0
`define BW_10KHZ      3'h2
`define BW_MAX        3'h5
`define MODE_WIDTH    2
`define MODE_POT      2'h0
`define MODE_GALV     2'h1
`define MODE_MAX      2'h2
`define OP_NONE       3'h0
`define OP_LOOPMODE   3'h1
`define OP_BANDWIDTH  3'h2
`define OP_BOOST      3'h3
`define OP_RESET      3'h4
`define OP_REVISION   3'h5
`define LINE_DEPTH    64
`define LINE_AW       6
`endif

/* cmd_char_norm.v */
// Character normaliser: folds letter case and classifies one ASCII byte
`include "cmd_consts.vh"
module cmd_char_norm (
  // Raw character
  input  wire [7:0] char_in,
  // Normalised character and classes
  output wire [7:0] upper_out,
  output wire       is_space_out,
  output wire       is_digit_out
);
  // Lower case letters map onto upper case
  assign upper_out    = (char_in >= 8'h61 && char_in <= 8'h7A) ? (char_in - 8'h20) : char_in;
  assign is_space_out = (char_in == `CH_SPACE);
  assign is_digit_out = (char_in >= `CH_ZERO) && (char_in <= `CH_NINE);
endmodule // cmd_char_norm

/* cmd_parser.v */
// Remote command line parser with boosted-mode bandwidth guard
// Notes on behaviour
// R1 - While boosted, the applied bandwidth never goes faster than the 10 kHz setting.
// R2 - While boosted, a request for more than 10 kHz bandwidth raises an error.
// R3 - Outside boosted mode every bandwidth setting up to 1 MHz is accepted.
// R4 - The common reset command restores defaults and leaves boosted mode.
// R5 - A host cabled for boost follows a common reset with boost enable 1.
// R6 - Command text is ASCII and letter case in names does not matter.
// R7 - Spaces anywhere inside a command are ignored.
// R8 - Semicolons split a buffered line whose commands run left to right.
// R9 - Numbers in scientific notation are rejected as arguments.
// R10 - Loop mode with argument 1 selects galvanostat mode.
// R11 - The revision query (FPGARV?) returns the programmable logic revision number; the boost enable query (BSTREN?) returns the boosted state.
// R12 - Entering boosted mode selects the 10 kHz bandwidth setting.
// R13 - Boost enable with argument 1 enters boosted mode.
// R14 - A line runs only after its terminator arrives.
`include "cmd_consts.vh"
module cmd_parser #(
  parameter DEPTH    = `LINE_DEPTH,
  parameter AW       = `LINE_AW,
  parameter [7:0] REVISION = 8'h01  // Arbitrary revision value
) (
  // Clock and reset
  input  wire                   clk_in,
  input  wire                   reset_n_in,
  // Incoming characters
  input  wire                   char_valid_in,
  input  wire [7:0]             char_in,
  output reg                    char_ready_out,
  // Front panel bandwidth request
  input  wire                   panel_bw_valid_in,
  input  wire [`BW_WIDTH-1:0]   panel_bw_in,
  // Settings and status
  output reg                    boosted_out,
  output reg  [`BW_WIDTH-1:0]   bandwidth_out,
  output reg  [`MODE_WIDTH-1:0] loop_mode_out,
  output reg                    error_out,
  output reg                    reply_valid_out,
  output reg  [7:0]             reply_out,
  output reg                    line_done_out
);
  localparam S_RECV = 2'h0;
  localparam S_EXEC = 2'h1;
  localparam S_DONE = 2'h2;

  reg [7:0]     line_mem [0:DEPTH-1];
  reg [AW-1:0]  wr_ptr_ff;
  reg [AW-1:0]  rd_ptr_ff;
  reg [1:0]     state_ff;
  reg [47:0]    name_ff;
  reg           query_ff;
  reg           arg_seen_ff;
  reg           arg_neg_ff;
  reg           arg_bad_ff;
  reg [7:0]     arg_ff;
  reg           overflow_ff;
  reg           name_long_ff;

  wire [7:0] rd_char;
  wire [7:0] up_char;
  wire       is_space;
  wire       is_digit;
  wire       at_end;
  wire       is_term;

  assign rd_char = line_mem[rd_ptr_ff];
  assign at_end  = (rd_ptr_ff == wr_ptr_ff);
  assign is_term = (char_in == `CH_LF) || (char_in == `CH_CR);

  cmd_char_norm u_norm (
    .char_in      (rd_char),
    .upper_out    (up_char),
    .is_space_out (is_space),
    .is_digit_out (is_digit)
  );

  // Command names as folded characters, right aligned in the six byte window
  localparam [47:0] NAME_LOOPMODE  = {8'h45, 8'h43, 8'h4D, 8'h4F, 8'h44, 8'h45};
  localparam [47:0] NAME_BANDWIDTH = {8'h43, 8'h4C, 8'h42, 8'h57, 8'h54, 8'h48};
  localparam [47:0] NAME_BOOST     = {8'h42, 8'h53, 8'h54, 8'h52, 8'h45, 8'h4E};
  localparam [47:0] NAME_RESET     = {8'h00, 8'h00, 8'h2A, 8'h52, 8'h53, 8'h54};
  localparam [47:0] NAME_REVISION  = {8'h46, 8'h50, 8'h47, 8'h41, 8'h52, 8'h56};

  // Command name decode
  reg [2:0] op;
  always @* begin
    case (name_ff)
      NAME_LOOPMODE:  op = `OP_LOOPMODE;
      NAME_BANDWIDTH: op = `OP_BANDWIDTH;
      NAME_BOOST:     op = `OP_BOOST;
      NAME_RESET:     op = `OP_RESET;
      NAME_REVISION:  op = `OP_REVISION;
      default:        op = `OP_NONE;
    endcase
  end

  // Decimal accumulator kept wider than the argument so overflow is seen
  wire [11:0] arg_wide;
  assign arg_wide = ({4'h0, arg_ff} * 12'h00A) + {8'h00, up_char[3:0]};

  // Character classes at the scan position
  wire is_sign;
  wire is_query;
  wire name_full;
  assign is_sign   = (up_char == `CH_PLUS) || (up_char == `CH_MINUS);
  assign is_query  = (up_char == `CH_QUERY);
  assign name_full = (name_ff[47:40] != 8'h00);

  // Decode of the command whose end the scan has reached
  wire arg_ok;
  wire arg_plain;
  wire cmd_end;
  wire set_loop;
  wire set_bw;
  wire bw_refused;
  wire boost_on;
  wire boost_off;
  wire do_reset;
  wire ask_rev;
  wire ask_boost;
  wire cmd_known;
  wire cmd_bad;
  assign arg_ok     = arg_seen_ff && !arg_bad_ff;
  assign arg_plain  = arg_ok && !arg_neg_ff && !query_ff && !name_long_ff;
  assign cmd_end    = at_end || (rd_char == `CH_SEMI);
  assign set_loop   = (op == `OP_LOOPMODE) && arg_plain && (arg_ff <= {6'h00, `MODE_MAX});
  assign set_bw     = (op == `OP_BANDWIDTH) && arg_plain && (arg_ff <= {5'h00, `BW_MAX});
  assign bw_refused = set_bw && boosted_out && (arg_ff < {5'h00, `BW_10KHZ});
  assign boost_on   = (op == `OP_BOOST) && arg_plain && (arg_ff == 8'h01);
  assign boost_off  = (op == `OP_BOOST) && arg_plain && (arg_ff == 8'h00);
  assign do_reset   = (op == `OP_RESET) && !arg_seen_ff && !query_ff && !name_long_ff;
  assign ask_rev    = (op == `OP_REVISION) && query_ff && !arg_seen_ff && !name_long_ff;
  assign ask_boost  = (op == `OP_BOOST) && query_ff && !arg_seen_ff && !name_long_ff;
  assign cmd_known  = set_loop || set_bw || boost_on || boost_off || do_reset || ask_rev
                      || ask_boost;
  // Anything that is not an empty command and not understood raises an error
  assign cmd_bad    = !cmd_known
                      && (name_ff != 48'h0 || arg_seen_ff || query_ff || name_long_ff);

  // Front panel requests go through the same boost guard as remote ones
  wire panel_bad;
  wire panel_refused;
  wire panel_apply;
  assign panel_bad     = panel_bw_valid_in && (panel_bw_in > `BW_MAX);
  assign panel_refused = panel_bw_valid_in && boosted_out && (panel_bw_in < `BW_10KHZ);
  assign panel_apply   = panel_bw_valid_in && !panel_bad && !panel_refused;

  // Buffer write side
  always @(posedge clk_in) begin
    if (state_ff == S_RECV && char_valid_in && !is_term && !overflow_ff) begin
      line_mem[wr_ptr_ff] <= char_in;  // [R8]
    end
  end

  // Line intake and scan sequencing
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff       <= S_RECV;
      wr_ptr_ff      <= {AW{1'b0}};
      rd_ptr_ff      <= {AW{1'b0}};
      overflow_ff    <= 1'b0;
      char_ready_out <= 1'b1;
    end else begin
      case (state_ff)
        S_RECV: begin
          if (char_valid_in) begin
            // Intake pauses from the terminator until the line has been run
            if (is_term) begin
              state_ff       <= S_EXEC;  // [R14]
              char_ready_out <= 1'b0;
              rd_ptr_ff      <= {AW{1'b0}};
            end else if (wr_ptr_ff == DEPTH - 1) begin
              overflow_ff <= 1'b1;
            end else if (!overflow_ff) begin
              wr_ptr_ff <= wr_ptr_ff + 1'b1;  // [R8]
            end
          end
        end
        S_EXEC: begin
          // A line that outgrew the buffer still runs its first DEPTH-1 bytes, short of its last stored byte
          if (at_end) begin
            state_ff <= S_DONE;
          end else begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;  // [R8]
          end
        end
        S_DONE: begin
          wr_ptr_ff      <= {AW{1'b0}};
          rd_ptr_ff      <= {AW{1'b0}};
          overflow_ff    <= 1'b0;
          char_ready_out <= 1'b1;
          state_ff       <= S_RECV;
        end
        default: state_ff <= S_RECV;
      endcase
    end
  end

  // Name and argument gathering while the line is scanned
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      name_ff      <= 48'h0;
      name_long_ff <= 1'b0;
      query_ff     <= 1'b0;
      arg_seen_ff  <= 1'b0;
      arg_neg_ff   <= 1'b0;
      arg_bad_ff   <= 1'b0;
      arg_ff       <= 8'h00;
    end else if (state_ff == S_EXEC) begin
      if (cmd_end) begin
        // Each command starts from a clean slate
        name_ff      <= 48'h0;
        name_long_ff <= 1'b0;
        query_ff     <= 1'b0;
        arg_seen_ff  <= 1'b0;
        arg_neg_ff   <= 1'b0;
        arg_bad_ff   <= 1'b0;
        arg_ff       <= 8'h00;
      end else if (is_space) begin
        name_ff <= name_ff;  // [R7]
      end else if (is_query && !arg_seen_ff) begin
        query_ff <= 1'b1;
      end else if (is_digit) begin
        // Command names hold no digits, so a digit always belongs to the argument
        arg_seen_ff <= 1'b1;
        arg_ff      <= arg_wide[7:0];
        if (arg_wide[11:8] != 4'h0) begin
          arg_bad_ff <= 1'b1;
        end
      end else if (is_sign && !arg_seen_ff) begin
        arg_seen_ff <= 1'b1;
        arg_neg_ff  <= (up_char == `CH_MINUS);
      end else if (arg_seen_ff) begin
        arg_bad_ff <= 1'b1;  // [R9]
      end else begin
        name_ff <= {name_ff[39:0], up_char};  // [R6]
        // A name longer than the window must not alias a shorter one
        if (name_full) begin
          name_long_ff <= 1'b1;
        end
      end
    end
  end

  // Settings, replies and status pulses
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      boosted_out     <= 1'b0;
      bandwidth_out   <= `BW_1MHZ;
      loop_mode_out   <= `MODE_POT;
      error_out       <= 1'b0;
      reply_valid_out <= 1'b0;
      reply_out       <= 8'h00;
      line_done_out   <= 1'b0;
    end else begin
      error_out       <= 1'b0;
      reply_valid_out <= 1'b0;
      line_done_out   <= (state_ff == S_DONE);
      // Panel first, so that a command ending in the same cycle wins
      if (panel_bad || panel_refused) begin
        error_out <= 1'b1;  // [R1] [R2]
      end else if (panel_apply) begin
        bandwidth_out <= panel_bw_in;  // [R3]
      end
      if (state_ff == S_EXEC && cmd_end) begin
        if (set_loop) begin
          loop_mode_out <= arg_ff[`MODE_WIDTH-1:0];  // [R10]
        end
        if (bw_refused) begin
          error_out <= 1'b1;  // [R1] [R2]
        end else if (set_bw) begin
          bandwidth_out <= arg_ff[`BW_WIDTH-1:0];  // [R3]
        end
        // A second boost enable while boosted leaves the bandwidth alone
        if (boost_on && !boosted_out) begin
          boosted_out   <= 1'b1;  // [R13]
          bandwidth_out <= `BW_10KHZ;  // [R12]
        end
        // Leaving boost keeps the bandwidth that was in force
        if (boost_off) begin
          boosted_out <= 1'b0;
        end
        if (do_reset) begin
          boosted_out   <= 1'b0;  // [R4]
          bandwidth_out <= `BW_1MHZ;
          loop_mode_out <= `MODE_POT;
        end
        if (ask_rev) begin
          reply_valid_out <= 1'b1;  // [R11]
          reply_out       <= REVISION;
        end
        if (ask_boost) begin
          reply_valid_out <= 1'b1;
          reply_out       <= {7'h00, boosted_out};
        end
        if (cmd_bad) begin
          error_out <= 1'b1;  // [R9]
        end
      end
      if (state_ff == S_DONE && overflow_ff) begin
        error_out <= 1'b1;
      end
    end
  end
endmodule // cmd_parser

/* cmd_parser_asserts.sv */
// Port-level checks for the command parser
`include "cmd_consts.vh"
module cmd_parser_asserts (
  // Clock and reset
  input wire                 clk_in,
  input wire                 reset_n_in,
  // Watched ports
  input wire                 char_valid_in,
  input wire [7:0]           char_in,
  input wire                 char_ready_out,
  input wire                 panel_bw_valid_in,
  input wire [`BW_WIDTH-1:0] panel_bw_in,
  input wire                 boosted_out,
  input wire [`BW_WIDTH-1:0] bandwidth_out,
  input wire                 error_out,
  input wire                 line_done_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // Panel request made while no line is executing
  wire panel_ok = panel_bw_valid_in && char_ready_out;
  a_boost_floor: assert property (boosted_out |-> bandwidth_out >= `BW_10KHZ)
    else $error("bandwidth above floor while boosted");
  a_boost_entry: assert property ($rose(boosted_out) |-> bandwidth_out == `BW_10KHZ)
    else $error("boost entered without floor setting");
  a_boost_source: assert property ($rose(boosted_out) |-> !$past(char_ready_out))
    else $error("boost entered outside line execution");
  a_term_stops: assert property (char_valid_in && char_ready_out &&
      (char_in == `CH_LF || char_in == `CH_CR) |=> !char_ready_out)
    else $error("terminator did not stop intake");
  a_panel_refuse: assert property (panel_ok && boosted_out &&
      panel_bw_in < `BW_10KHZ |-> ##[1:2] error_out)
    else $error("fast panel request not refused");
  a_panel_keep: assert property (panel_ok && boosted_out &&
      panel_bw_in < `BW_10KHZ |=> $stable(bandwidth_out))
    else $error("refused panel request changed bandwidth");
  a_panel_apply: assert property (panel_ok && !boosted_out &&
      panel_bw_in <= `BW_MAX |=> bandwidth_out == $past(panel_bw_in))
    else $error("panel request not applied");
  a_done_pulse: assert property (line_done_out |=> !line_done_out)
    else $error("line done longer than one cycle");
endmodule // cmd_parser_asserts
bind cmd_parser cmd_parser_asserts cmd_parser_asserts_i (.clk_in, .reset_n_in,
  .char_valid_in, .char_in, .char_ready_out, .panel_bw_valid_in, .panel_bw_in,
  .boosted_out, .bandwidth_out, .error_out, .line_done_out);

/* host_model.sv */
// Remote host model sending command lines byte by byte
module host_model (
  input  wire        clk_in,
  input  wire        char_ready_out,
  output logic       char_valid_in,
  output logic [7:0] char_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    char_valid_in = 1'b0;
    char_in = 8'h00;
  end
  // Each byte is held until the edge that takes it
  task automatic send_line(input string s, input bit term);
    int i;
    for (i = 0; i < s.len() + int'(term); i++) begin
      @(negedge clk_in);
      char_valid_in = 1'b1;
      char_in = (i == s.len()) ? 8'h0A : s[i];
      while (char_ready_out !== 1'b1) @(negedge clk_in);
      @(posedge clk_in);
    end
    @(negedge clk_in);
    char_valid_in = 1'b0;
    char_in = ~char_in;
  endtask
endmodule // host_model

/* remote_cmd_parser_boost_guard_test.sv */
// Self-checking bench for the command parser
`include "cmd_consts.vh"
module remote_cmd_parser_boost_guard_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, reset_n_in, char_valid_in, char_ready_out, panel_bw_valid_in;
  logic boosted_out, error_out, reply_valid_out, line_done_out, exp_boost;
  logic [7:0] char_in, reply_out, last_reply;
  logic [2:0] panel_bw_in, bandwidth_out, exp_bw;
  logic [1:0] loop_mode_out;
  int errors, total_checks, err_seen;
  string boost;
  cmd_parser cmd_parser_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .char_valid_in(char_valid_in), .char_in(char_in), .char_ready_out(char_ready_out),
    .panel_bw_valid_in(panel_bw_valid_in), .panel_bw_in(panel_bw_in),
    .boosted_out(boosted_out), .bandwidth_out(bandwidth_out), .loop_mode_out(loop_mode_out),
    .error_out(error_out), .reply_valid_out(reply_valid_out), .reply_out(reply_out),
    .line_done_out(line_done_out));
  host_model host_model_i (.clk_in(clk_in), .char_ready_out(char_ready_out),
    .char_valid_in(char_valid_in), .char_in(char_in));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(negedge clk_in) begin
    if (error_out === 1'b1) err_seen++;
    if (reply_valid_out === 1'b1) last_reply = reply_out;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  function bit refused(input bit b, input int c);
    return c > 5 || (b && c < 2);
  endfunction
  task run(input string s);
    int i;
    err_seen = 0;
    last_reply = 8'hEE;
    host_model_i.send_line(s, 1'b1);
    for (i = 0; i < 400 && line_done_out !== 1'b1; i++) @(negedge clk_in);
    check(line_done_out, 8'h01);
    @(negedge clk_in);
  endtask
  task panel(input int code);
    err_seen = 0;
    panel_bw_valid_in = 1'b1;
    panel_bw_in = 3'(code);
    @(negedge clk_in);
    panel_bw_valid_in = 1'b0;
    repeat (3) @(negedge clk_in);
  endtask
  task rand_bw(input int count);
    int n, code;
    for (n = 0; n < count; n++) begin
      code = $urandom % 7;
      if (n % 2) run($sformatf("ClBw th %0d", code));
      else panel(code);
      check(8'(err_seen), 8'(refused(exp_boost, code)));
      if (!refused(exp_boost, code)) exp_bw = 3'(code);
      check(bandwidth_out, exp_bw);
    end
  endtask
  task finish_test;
    $display("errors=%0d checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    reset_n_in = 1'b0;
    panel_bw_valid_in = 1'b0;
    panel_bw_in = 3'h0;
    errors = 0;
    total_checks = 0;
    boost = {"BST", "REN"};
    void'($urandom(32'hFBCF));
    repeat (20) @(negedge clk_in);
    reset_n_in = 1'b1;
    run("ECMODE 1");
    check(loop_mode_out, `MODE_GALV);
    run("eC mOdE   0");
    check(loop_mode_out, `MODE_POT);
    check(8'(err_seen), 8'h00);
    run("clbwth 0 ;ecmode 1; clbwth 4");
    check(bandwidth_out, 3'h4);
    check(loop_mode_out, `MODE_GALV);
    run("ecmode 2;ecmode 3;xecmode 1");
    check(loop_mode_out, 2'h2);
    check(8'(err_seen), 8'h02);
    run("clbwth -1.2e3");
    check(8'(err_seen), 8'h01);
    host_model_i.send_line("clbwth 5", 1'b0);
    repeat (20) @(negedge clk_in);
    check(bandwidth_out, 3'h4);
    run("");
    check(bandwidth_out, 3'h5);
    run({boost, " 1"});
    check(boosted_out, 8'h01);
    check(bandwidth_out, `BW_10KHZ);
    run({boost, "?"});
    check(last_reply, 8'h01);
    exp_boost = 1'b1;
    exp_bw = `BW_10KHZ;
    rand_bw(10);
    run("clbwth 1;clbwth 0;clbwth 3");
    check(8'(err_seen), 8'h02);
    check(bandwidth_out, 3'h3);
    run("fpgarv?");
    check(last_reply, 8'h01);
    run("*RST");
    check(boosted_out, 8'h00);
    check(bandwidth_out, `BW_1MHZ);
    check(loop_mode_out, `MODE_POT);
    run({boost, "1"});
    check(boosted_out, 8'h01);
    run({boost, " 0"});
    run({boost, " ?"});
    check(last_reply, 8'h00);
    exp_boost = 1'b0;
    exp_bw = `BW_10KHZ;
    rand_bw(10);
    run("clbwth 0");
    check(bandwidth_out, `BW_1MHZ);
    finish_test;
  end
  initial begin
    #1000000;
    errors++;
    finish_test;
  end
endmodule // remote_cmd_parser_boost_guard_test
